/* core/rll_cfg_if.sv */
`timescale 1ns/10ps

interface rll_cfg_if;
   rll_pkg::rll_cfg_word_t word;
   logic                   loaded;

   modport port (output word, output loaded);
   modport core (input word, input loaded);
endinterface

/* core/rll_cfg_port.sv */
`timescale 1ns/10ps
`include "rll_consts.svh"

module rll_cfg_port (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // Serial configuration pins
   input  wire logic i_cfg_clk,
   input  wire logic i_cfg_serial_in,
   input  wire logic i_cfg_latch_shift_sel,
   // Latched word toward the core
   rll_cfg_if.port   cfg
);

   // ==========================================================
   // Pin filters: three flops, a change counts once 2nd and 3rd agree
   logic [2:0] raw;
   logic [2:0] s1;
   logic [2:0] s2;
   logic [2:0] s3;
   logic [2:0] lvl;
   logic [2:0] rise;

   assign raw = {i_cfg_latch_shift_sel, i_cfg_clk, i_cfg_serial_in};

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_pin
         always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               s1[g]  <= 1'b0;
               s2[g]  <= 1'b0;
               s3[g]  <= 1'b0;
               lvl[g] <= 1'b0;
            end else begin
               s1[g] <= raw[g];
               s2[g] <= s1[g];
               s3[g] <= s2[g];
               if (s2[g] == s3[g]) begin
                  lvl[g] <= s3[g];
               end
            end
         end
         assign rise[g] = (s2[g] == s3[g]) && s3[g] && !lvl[g];
      end
   endgenerate

   // ==========================================================
   // Shift register and holding latch
   rll_pkg::rll_cfg_word_t shreg;
   rll_pkg::rll_cfg_word_t latch;
   logic                   loaded;
   wire                    do_shift = rise[1] && !lvl[2];
   wire                    do_latch = rise[2];

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         shreg <= `RLL_CFG_WIDTH'h0;
      end else if (do_shift) begin
         shreg <= {shreg[`RLL_CFG_MSB-1:0], lvl[0]};
      end
   end

   // Reset value keeps the part in normal operation until software loads it
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         latch  <= `RLL_CFG_RESET;
         loaded <= 1'b0;
      end else begin
         loaded <= do_latch;
         if (do_latch) begin
            latch <= shreg;
         end
      end
   end

   assign cfg.word   = latch;
   assign cfg.loaded = loaded;

endmodule

/* core/rll_consts.svh */
`ifndef RLL_CONSTS_SVH
`define RLL_CONSTS_SVH

// ==========================================================
// Configuration word layout
`define RLL_CFG_WIDTH     14
`define RLL_CFG_MSB       13
`define RLL_CFG_RESET     14'h0400
`define RLL_CFG_PD_A      1
`define RLL_CFG_PD_B      2
`define RLL_CFG_INVERT    4
`define RLL_CFG_DIFF      6
`define RLL_CFG_BYP_A     7
`define RLL_CFG_BYP_B     8
`define RLL_CFG_INT_WCLK  9
`define RLL_CFG_NORMAL    10
`define RLL_CFG_ENC_BYP   11

// ==========================================================
// Timing counts: write phases in core clock cycles, read phase in sync clock cycles
`define RLL_WPH_LAST      3'h5
`define RLL_WCLK_HIGH     3'h3
`define RLL_RPH_LAST      2'h2

// ==========================================================
// Decode window and pin vector layout
`define RLL_WIN_MSB       8
`define RLL_PIN_COUNT     5
`define RLL_PIN_WG        4
`define RLL_PIN_RG        3
`define RLL_PIN_EWCLK     2
`define RLL_PIN_MSB       1
`define RLL_PIN_LSB       0

`endif

/* core/rll_line_codec.sv */
`timescale 1ns/10ps
`include "rll_consts.svh"

// How it works
// - Fourteen-bit shift register feeds parallel holding latch
// - Shift config bit on config clock while low
// - Select going high copies shift into latch
// - Bits 1 and 2 set means power down
// - Bit 4 inverts the coded output stream
// - Bit 6 selects differential coded output pair
// - Bits 7,8 pick none, precomp bypass, tristate
// - Bit 9 selects the internal write clock
// - Bit 11, with bits 7,8 both clear, passes NRZ bit 0 straight out
// - Read/reference clock switches without glitch, only while both sources are low
// - NRZ side moves two bits per clock
// - Nine-bit window, middle three bits decoded
// - Window bit 8 oldest, new bits at 0
// - LSB: bit5, or bits 4,3 both zero
// - MSB: bit3, or 6..4 zero, or 2..0 zero
// - Encoder state starts at zero each sequence
// - State plus pair selects code and next state
// - Next state used for the following pair
module rll_line_codec (
   // Clocks and reset
   input  wire logic i_clk,
   input  wire logic i_sync_clk,
   input  wire logic i_reset_n,
   // Serial configuration
   input  wire logic i_cfg_clk,
   input  wire logic i_cfg_serial_in,
   input  wire logic i_cfg_latch_shift_sel,
   // Controller side
   input  wire logic i_write_gate,
   input  wire logic i_read_gate,
   input  wire logic i_ext_write_clk,
   input  wire logic i_nrz_msb_io,
   input  wire logic i_nrz_lsb_io,
   output logic      o_nrz_msb_io,
   output logic      o_nrz_lsb_io,
   output logic      o_nrz_oe,
   output logic      o_write_clk,
   output logic      o_read_ref_clock_out,
   // Read channel side
   input  wire logic i_synced_code_in,
   output logic      o_coded_write_out,
   output logic      o_coded_write_out_n,
   output logic      o_code_oe,
   output logic      o_code_diff_en,
   output logic      o_early,
   output logic      o_late
);

   // ==========================================================
   // Configuration
   rll_cfg_if cfg_bus ();

   rll_cfg_port u_cfg (
      .i_clk                 (i_clk),
      .i_reset_n             (i_reset_n),
      .i_cfg_clk             (i_cfg_clk),
      .i_cfg_serial_in       (i_cfg_serial_in),
      .i_cfg_latch_shift_sel (i_cfg_latch_shift_sel),
      .cfg                   (cfg_bus.port)
   );

   wire rll_pkg::rll_cfg_word_t word = cfg_bus.word;
   wire pd       = word[`RLL_CFG_PD_A] && word[`RLL_CFG_PD_B];
   wire invert   = word[`RLL_CFG_INVERT];
   wire diff     = word[`RLL_CFG_DIFF];
   wire byp_a    = word[`RLL_CFG_BYP_A];
   wire byp_b    = word[`RLL_CFG_BYP_B];
   wire tristate = byp_a && byp_b;
   wire pc_byp   = !byp_a && byp_b;
   wire enc_byp  = word[`RLL_CFG_ENC_BYP] && !byp_a && !byp_b;
   wire int_wclk = word[`RLL_CFG_INT_WCLK];

   // ==========================================================
   // Pin filters on the core clock
   logic [`RLL_PIN_COUNT-1:0] pin_raw;
   logic [`RLL_PIN_COUNT-1:0] pin_s1;
   logic [`RLL_PIN_COUNT-1:0] pin_s2;
   logic [`RLL_PIN_COUNT-1:0] pin_s3;
   logic [`RLL_PIN_COUNT-1:0] pin_lvl;

   assign pin_raw = {i_write_gate, i_read_gate, i_ext_write_clk, i_nrz_msb_io, i_nrz_lsb_io};

   genvar g;
   generate
      for (g = 0; g < `RLL_PIN_COUNT; g = g + 1) begin : g_pin
         always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               pin_s1[g]  <= 1'b0;
               pin_s2[g]  <= 1'b0;
               pin_s3[g]  <= 1'b0;
               pin_lvl[g] <= 1'b0;
            end else begin
               pin_s1[g] <= pin_raw[g];
               pin_s2[g] <= pin_s1[g];
               pin_s3[g] <= pin_s2[g];
               if (pin_s2[g] == pin_s3[g]) begin
                  pin_lvl[g] <= pin_s3[g];
               end
            end
         end
      end
   endgenerate

   wire wg       = pin_lvl[`RLL_PIN_WG];
   wire rg       = pin_lvl[`RLL_PIN_RG];
   wire nrz_msb  = pin_lvl[`RLL_PIN_MSB];
   wire nrz_lsb  = pin_lvl[`RLL_PIN_LSB];
   wire ext_rise = (pin_s2[`RLL_PIN_EWCLK] == pin_s3[`RLL_PIN_EWCLK]) && pin_s3[`RLL_PIN_EWCLK]
                   && !pin_lvl[`RLL_PIN_EWCLK];

   // ==========================================================
   // Internal write clock divider, also the reference clock source
   logic [2:0] wph;
   logic       wclk_int;
   wire  [2:0] next_wph = (wph == `RLL_WPH_LAST) ? 3'h0 : wph + 3'h1;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wph      <= 3'h0;
         wclk_int <= 1'b0;
      end else begin
         wph      <= next_wph;
         wclk_int <= (next_wph < `RLL_WCLK_HIGH);
      end
   end

   // Divider period leaves the pin filters time to settle the NRZ pair
   wire strobe = int_wclk ? (wph == `RLL_WPH_LAST) : ext_rise;
   wire take   = strobe && wg && !pd;

   // ==========================================================
   // Encoder state table
   rll_pkg::rll_enc_state_t state;
   rll_pkg::rll_enc_state_t next_state;
   logic [2:0]              enc_code;

   always_comb begin
      next_state = rll_pkg::RLL_ST0;
      enc_code   = 3'h0;
      unique case (state)
         rll_pkg::RLL_ST0: enc_code = 3'h2;
         rll_pkg::RLL_ST1: enc_code = 3'h0;
         rll_pkg::RLL_ST2: enc_code = 3'h4;
         rll_pkg::RLL_ST3: enc_code = ({nrz_msb, nrz_lsb} == 2'h3) ? 3'h4 : 3'h5;
         rll_pkg::RLL_ST4: enc_code = ({nrz_msb, nrz_lsb} == 2'h3) ? 3'h2 : 3'h1;
         default:          enc_code = 3'h0;
      endcase
      if ((state == rll_pkg::RLL_ST3) || (state == rll_pkg::RLL_ST4)) begin
         unique case ({nrz_msb, nrz_lsb})
            2'h0:    next_state = rll_pkg::RLL_ST0;
            2'h1:    next_state = rll_pkg::RLL_ST1;
            2'h2:    next_state = rll_pkg::RLL_ST4;
            2'h3:    next_state = rll_pkg::RLL_ST1;
         endcase
      end else begin
         unique case ({nrz_msb, nrz_lsb})
            2'h0:    next_state = rll_pkg::RLL_ST0;
            2'h1:    next_state = rll_pkg::RLL_ST2;
            2'h2:    next_state = rll_pkg::RLL_ST4;
            2'h3:    next_state = rll_pkg::RLL_ST3;
         endcase
      end
   end

   // ==========================================================
   // Code serialiser: three code bits per pair, two core cycles each
   logic [2:0] code_sr;
   logic       half;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state   <= rll_pkg::RLL_ST0;
         code_sr <= 3'h0;
         half    <= 1'b0;
      end else if (!wg || pd) begin
         state   <= rll_pkg::RLL_ST0;
         code_sr <= 3'h0;
         half    <= 1'b0;
      end else if (take) begin
         state   <= next_state;
         code_sr <= enc_code;
         half    <= 1'b0;
      end else begin
         half <= !half;
         if (half) begin
            code_sr <= {code_sr[1:0], 1'b0};
         end
      end
   end

   wire serial_bit = enc_byp ? nrz_lsb : code_sr[2];
   wire bit_tick   = half || take;

   // ==========================================================
   // Precompensation history around the target bit
   logic [4:0] hist;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hist <= 5'h00;
      end else if (!wg || pd) begin
         hist <= 5'h00;
      end else if (bit_tick) begin
         hist <= {hist[3:0], serial_bit};
      end
   end

   wire pat_early = (hist == 5'h14);
   wire pat_late  = (hist == 5'h05);
   // Bypassing precomp skips the two-bit look-ahead delay
   wire code_bit  = ((pc_byp || enc_byp) ? serial_bit : hist[2]) ^ invert;

   // ==========================================================
   // Code outputs
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_coded_write_out   <= 1'b0;
         o_coded_write_out_n <= 1'b0;
         o_code_oe           <= 1'b0;
         o_code_diff_en      <= 1'b0;
         o_early             <= 1'b0;
         o_late              <= 1'b0;
         o_write_clk         <= 1'b0;
      end else begin
         o_coded_write_out   <= !pd && code_bit;
         o_coded_write_out_n <= !pd && diff && !code_bit;
         o_code_oe           <= !pd && !tristate;
         o_code_diff_en      <= !pd && diff;
         o_early             <= !pd && !pc_byp && !enc_byp && pat_early;
         o_late              <= !pd && !pc_byp && !enc_byp && pat_late;
         o_write_clk         <= wclk_int && (o_write_clk || ((wph == 3'h0) && int_wclk && !pd));
      end
   end

   // ==========================================================
   // Link domain: decode window on the sync clock
   logic [2:0]            lk_s;
   logic                  lk_gate;
   logic [`RLL_WIN_MSB:0] win;
   logic [1:0]            rph;
   logic [1:0]            lk_pair;
   logic                  lk_tog;

   always_ff @(posedge i_sync_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lk_s    <= 3'h0;
         lk_gate <= 1'b0;
      end else begin
         lk_s <= {lk_s[1:0], i_read_gate};
         if (lk_s[1] == lk_s[2]) begin
            lk_gate <= lk_s[2];
         end
      end
   end

   wire dec_lsb = win[5] || (!win[4] && !win[3]);
   wire dec_msb = win[3] || !(win[6] || win[5] || win[4]) || !(win[2] || win[1] || win[0]);

   always_ff @(posedge i_sync_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         win     <= 9'h000;
         rph     <= 2'h0;
         lk_pair <= 2'h0;
         lk_tog  <= 1'b0;
      end else begin
         win <= {win[`RLL_WIN_MSB-1:0], i_synced_code_in};
         if (!lk_gate) begin
            rph <= 2'h0;
         end else if (rph == `RLL_RPH_LAST) begin
            rph     <= 2'h0;
            lk_pair <= {dec_msb, dec_lsb};
            lk_tog  <= !lk_tog;
         end else begin
            rph <= rph + 2'h1;
         end
      end
   end

   // ==========================================================
   // Crossing: toggle handshake, pair word stable for three sync cycles
   logic t1;
   logic t2;
   logic t3;
   wire  arrival = t2 ^ t3;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         t1 <= 1'b0;
         t2 <= 1'b0;
         t3 <= 1'b0;
      end else begin
         t1 <= lk_tog;
         t2 <= t1;
         t3 <= t2;
      end
   end

   // ==========================================================
   // NRZ read outputs and read/reference clock
   logic rd_d1;
   logic rd_d2;
   logic rr_sel;
   wire  rd_src  = rd_d1 || rd_d2;
   wire  rr_next = rr_sel ? rd_src : wclk_int;
   wire  rr_start = rr_sel ? (rd_d1 && !rd_d2) : (wph == 3'h0);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_nrz_msb_io         <= 1'b0;
         o_nrz_lsb_io         <= 1'b0;
         o_nrz_oe             <= 1'b0;
         rd_d1                <= 1'b0;
         rd_d2                <= 1'b0;
         rr_sel               <= 1'b0;
         o_read_ref_clock_out <= 1'b0;
      end else begin
         if (arrival) begin
            {o_nrz_msb_io, o_nrz_lsb_io} <= lk_pair;
         end
         o_nrz_oe <= !pd && rg && !wg;
         rd_d1    <= arrival;
         rd_d2    <= rd_d1;
         // Source changes only while both sources are low, though the output register may still be high
         if ((rr_sel != rg) && !rd_src && !wclk_int) begin
            rr_sel <= rg;
         end
         o_read_ref_clock_out <= rr_next && (o_read_ref_clock_out || (rr_start && !pd));
      end
   end

endmodule

/* core/rll_pkg.sv */
`include "rll_consts.svh"

package rll_pkg;

   // ==========================================================
   // Types
   typedef logic [`RLL_CFG_MSB:0] rll_cfg_word_t;

   typedef enum logic [4:0] {
      RLL_ST0 = 5'h01,
      RLL_ST1 = 5'h02,
      RLL_ST2 = 5'h04,
      RLL_ST3 = 5'h08,
      RLL_ST4 = 5'h10
   } rll_enc_state_t;

endpackage

/* sim/rll_chan_model.sv */
`timescale 1ns/10ps

// ==========
// Controller config port and read channel
module rll_chan_model (
   // Core clock
   input  wire logic i_clk,
   // Configuration pins
   output logic      o_cfg_clk,
   output logic      o_cfg_data,
   output logic      o_cfg_sel,
   // Read channel pins
   output logic      o_sync_clk,
   output logic      o_code
);
   initial begin
      o_cfg_clk = 1'b0;
      o_cfg_data = 1'b0;
      o_cfg_sel = 1'b0;
      o_sync_clk = 1'b0;
      o_code = 1'b0;
   end

   task automatic ticks(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // Edges are slow since the pins pass a three-flop filter
   task automatic load(input logic [13:0] word);
      logic [13:0] w;
      w = (word & ~14'h3029) | 14'h0400;
      for (int i = 13; i >= 0; i--) begin
         o_cfg_data = w[i];
         ticks(5);
         o_cfg_clk = 1'b1;
         ticks(6);
         o_cfg_clk = 1'b0;
         ticks(6);
      end
      o_cfg_sel = 1'b1;
      ticks(10);
      o_cfg_sel = 1'b0;
      ticks(4);
   endtask

   // Sync clock runs only while bits are sent
   task automatic play(input logic [1:0] bits[$]);
      foreach (bits[i]) begin
         o_code = bits[i][0];
         #15 o_sync_clk = 1'b1;
         #15 o_sync_clk = 1'b0;
      end
      o_code = ~o_code;
   endtask
endmodule

/* sim/rll_line_codec_checker.sv */
`timescale 1ns/10ps

// ==========
// Pin-level checks on the codec top
module rll_line_codec_checker (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Controller side
   input wire logic i_read_gate,
   input wire logic i_write_gate,
   input wire logic o_nrz_msb_io,
   input wire logic o_nrz_lsb_io,
   input wire logic o_nrz_oe,
   input wire logic o_write_clk,
   input wire logic o_read_ref_clock_out,
   // Read channel side
   input wire logic o_coded_write_out,
   input wire logic o_coded_write_out_n,
   input wire logic o_code_oe,
   input wire logic o_code_diff_en,
   input wire logic o_early,
   input wire logic o_late
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   AST_WCLK_HIGH: assert property (
      $rose(o_write_clk) |-> o_write_clk [*3] ##1 !o_write_clk)
      else $error("write clock high phase wrong");
   AST_WCLK_LOW: assert property (
      $fell(o_write_clk) |-> !o_write_clk [*3])
      else $error("write clock low phase short");
   AST_READ_REF_CLOCK_OUT_HIGH: assert property (
      $rose(o_read_ref_clock_out) |=> o_read_ref_clock_out)
      else $error("runt high on read clock");
   AST_READ_REF_CLOCK_OUT_LOW: assert property (
      $fell(o_read_ref_clock_out) |=> !o_read_ref_clock_out)
      else $error("runt low on read clock");
   AST_NRZ_HOLD: assert property (
      o_read_ref_clock_out |-> $stable({o_nrz_msb_io, o_nrz_lsb_io}))
      else $error("read pair moved while read clock high");
   AST_DIFF_COMPL: assert property (
      o_code_diff_en && $past(o_code_diff_en) && o_code_oe |-> o_coded_write_out_n != o_coded_write_out)
      else $error("differential pair not complementary");
   AST_OE_ROSE: assert property (
      $rose(o_nrz_oe) |-> $past(i_read_gate, 2) && !$past(i_write_gate, 2))
      else $error("read pins driven without read gate");
   AST_OE_FELL: assert property (
      $fell(i_read_gate) |-> ##6 !o_nrz_oe)
      else $error("read pins still driven after read gate");
   AST_PRECOMP_EXCL: assert property (
      o_early |-> !o_late)
      else $error("early and late together");
endmodule

bind rll_line_codec rll_line_codec_checker i_chk (
   .i_clk, .i_reset_n, .i_read_gate, .i_write_gate, .o_nrz_msb_io, .o_nrz_lsb_io, .o_nrz_oe,
   .o_write_clk, .o_read_ref_clock_out, .o_coded_write_out, .o_coded_write_out_n, .o_code_oe,
   .o_code_diff_en, .o_early, .o_late
);

/* sim/test_rll_line_codec.sv */
`timescale 1ns/10ps

module test_rll_line_codec;
   // ==========
   // Pins and bench state
   logic       i_clk = 1'b0, i_reset_n = 1'b0, i_write_gate = 1'b0, i_read_gate = 1'b0;
   logic       i_ext_write_clk = 1'b0;
   logic [1:0] nrz_drv = 2'h0;
   wire        i_nrz_msb_io, i_nrz_lsb_io, i_sync_clk, i_cfg_clk, i_cfg_serial_in;
   wire        i_cfg_latch_shift_sel, i_synced_code_in;
   logic       o_nrz_msb_io, o_nrz_lsb_io, o_nrz_oe, o_write_clk, o_read_ref_clock_out;
   logic       o_coded_write_out, o_coded_write_out_n, o_code_oe, o_code_diff_en, o_early, o_late;
   logic [1:0] cap[$];
   logic       cap_wr = 1'b0, cap_rd = 1'b0, rr_q = 1'b0;
   int         n_errors = 0, samples_checked = 0;
   int         n_early = 0, n_late = 0;

   // Rows by state, three bits per input pair, pair 3 on top
   localparam logic [11:0] code_tab [5] = '{12'h492, 12'h000, 12'h924, 12'h96D, 12'h449};
   localparam logic [11:0] succ_tab [5] = '{12'h710, 12'h710, 12'h710, 12'h308, 12'h308};
   localparam logic [15:0] cfg_tab [6] = '{16'h8400, 16'h8402, 16'hC440, 16'h0446, 16'h0580, 16'h8500};
   localparam logic [47:0] data_word = 48'hD85A3CE196F7;

   // Shared NRZ wires: the device wins while it drives
   assign i_nrz_msb_io = o_nrz_oe ? o_nrz_msb_io : nrz_drv[1];
   assign i_nrz_lsb_io = o_nrz_oe ? o_nrz_lsb_io : nrz_drv[0];

   always #10 i_clk = ~i_clk;

   rll_line_codec i_dut (
      .i_clk, .i_sync_clk, .i_reset_n, .i_cfg_clk, .i_cfg_serial_in, .i_cfg_latch_shift_sel,
      .i_write_gate, .i_read_gate, .i_ext_write_clk, .i_nrz_msb_io, .i_nrz_lsb_io, .o_nrz_msb_io,
      .o_nrz_lsb_io, .o_nrz_oe, .o_write_clk, .o_read_ref_clock_out, .i_synced_code_in,
      .o_coded_write_out, .o_coded_write_out_n, .o_code_oe, .o_code_diff_en, .o_early, .o_late
   );

   rll_chan_model i_chan (
      .i_clk, .o_cfg_clk(i_cfg_clk), .o_cfg_data(i_cfg_serial_in), .o_cfg_sel(i_cfg_latch_shift_sel),
      .o_sync_clk(i_sync_clk), .o_code(i_synced_code_in)
   );

   // Read pairs are taken where the read clock rises
   always @(posedge i_clk) begin
      rr_q <= o_read_ref_clock_out;
      if (cap_wr) begin
         cap.push_back({1'b0, o_coded_write_out});
         n_early += int'(o_early);
         n_late  += int'(o_late);
      end
      if (cap_rd && o_read_ref_clock_out && !rr_q) cap.push_back({o_nrz_msb_io, o_nrz_lsb_io});
   end

   // ==========
   // Helpers
   task automatic ticks(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic void encode(output logic [1:0] cs[$]);
      int         st;
      logic [1:0] pr;
      cs = {};
      st = 0;
      for (int i = 0; i < 24; i++) begin
         pr = data_word[47 - 2 * i -: 2];
         for (int b = 2; b >= 0; b--) cs.push_back({1'b0, code_tab[st][pr * 3 + b]});
         st = int'(succ_tab[st][pr * 3 +: 3]);
      end
   endfunction

   // Alignment is searched, as latency differs by mode
   function automatic bit found(logic [1:0] h[$], logic [1:0] n[$]);
      bit ok;
      for (int i = 0; i + n.size() <= h.size(); i++) begin
         ok = 1'b1;
         foreach (n[j]) if (h[i + j] !== n[j]) ok = 1'b0;
         if (ok) return 1'b1;
      end
      return 1'b0;
   endfunction

   // ==========
   // Scenarios
   task automatic run_enc(input logic [13:0] w, input logic inv);
      logic [1:0] cs[$];
      logic [1:0] exp[$];
      logic [4:0] h;
      int         ee;
      int         el;
      i_chan.load(w);
      encode(cs);
      foreach (cs[i]) repeat (2) exp.push_back(cs[i] ^ {1'b0, inv});
      // Precomp windows over the raw code stream, zero padded at both ends
      h = 5'h00;
      ee = 0;
      el = 0;
      for (int i = 0; i < cs.size() + 2; i++) begin
         h = {h[3:0], (i < cs.size()) ? cs[i][0] : 1'b0};
         if (h == 5'h14) ee++;
         if (h == 5'h05) el++;
      end
      cap = {};
      n_early = 0;
      n_late = 0;
      i_write_gate = 1'b1;
      cap_wr = 1'b1;
      ticks(10);
      for (int i = 0; i < 24; i++) begin
         nrz_drv = data_word[47 - 2 * i -: 2];
         ticks(3);
         i_ext_write_clk = 1'b1;
         ticks(3);
         i_ext_write_clk = 1'b0;
      end
      ticks(30);
      cap_wr = 1'b0;
      i_write_gate = 1'b0;
      chk(14'(found(cap, exp)), 14'h1);
      chk(14'(n_early), w[8] ? 14'h0 : 14'(2 * ee));
      chk(14'(n_late), w[8] ? 14'h0 : 14'(2 * el));
   endtask

   task automatic run_byp(input logic [13:0] w, input logic inv);
      i_chan.load(w);
      i_write_gate = 1'b1;
      for (int v = 0; v < 4; v++) begin
         nrz_drv = {1'b0, v[0]};
         ticks(8);
         chk({13'h0, o_coded_write_out}, {13'h0, v[0] ^ inv});
      end
      i_write_gate = 1'b0;
   endtask

   task automatic run_dec;
      logic [1:0] cs[$];
      logic [1:0] exp[$];
      logic [1:0] tx[$];
      logic [8:0] w;
      bit         hit;
      i_chan.load(14'h0400);
      encode(cs);
      // Trailing bits give the last window its look-ahead edges
      tx = cs;
      repeat (3) tx.push_back(2'h0);
      i_read_gate = 1'b1;
      ticks(10);
      chk({13'h0, o_nrz_oe}, 14'h1);
      cap = {};
      cap_rd = 1'b1;
      #7 i_chan.play(tx);
      ticks(20);
      cap_rd = 1'b0;
      i_read_gate = 1'b0;
      hit = 1'b0;
      for (int p = 0; p < 3; p++) begin
         exp = {};
         for (int k = 8 + p; k < cs.size(); k += 3) begin
            for (int b = 0; b < 9; b++) w[b] = cs[k - b][0];
            exp.push_back({w[3] | ~|w[6:4] | ~|w[2:0], w[5] | ~|w[4:3]});
         end
         hit |= found(cap, exp);
      end
      chk(14'(hit), 14'h1);
   endtask

   task automatic results;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========
   // Main sequence
   initial begin
      int   n;
      logic wq;
      ticks(3);
      i_reset_n = 1'b1;
      ticks(5);
      foreach (cfg_tab[i]) begin
         i_chan.load(cfg_tab[i][13:0]);
         chk({11'h0, o_code_oe, o_code_diff_en, o_coded_write_out_n},
             {11'h0, cfg_tab[i][15:14], cfg_tab[i][14]});
      end
      run_enc(14'h0500, 1'b0);
      run_enc(14'h0400, 1'b0);
      run_enc(14'h0510, 1'b1);
      run_byp(14'h0C00, 1'b0);
      run_byp(14'h0C10, 1'b1);
      run_dec();
      // Internal write clock goes last: a pulse in flight finishes on a mode change, so no phase is cut
      i_chan.load(14'h0600);
      n = 0;
      wq = o_write_clk;
      repeat (60) begin
         ticks(1);
         if (o_write_clk && !wq) n++;
         wq = o_write_clk;
      end
      chk(14'(n), 14'hA);
      results();
   end

   initial begin
      #1000000;
      n_errors++;
      results();
   end
endmodule
